/* File: tmsc_pkg.sv */
package tmsc_pkg;

    // register offsets
    localparam logic [7:0] TMSC_ADDR_STATUS   = 8'h00;
    localparam logic [7:0] TMSC_ADDR_CONFIG   = 8'h44;

    // status register fields
    localparam int         TMSC_ST_OCF_BIT    = 7;
    localparam int         TMSC_ST_TOUCH_LSB  = 0;
    localparam int         TMSC_NUM_INPUTS    = 3;

    // configuration register fields
    localparam int         TMSC_CFG_CAL_BIT   = 6;
    localparam int         TMSC_CFG_MODE_MSB  = 5;
    localparam int         TMSC_CFG_MODE_LSB  = 4;
    localparam int         TMSC_CFG_EN_MSB    = 3;
    localparam int         TMSC_CFG_EN_LSB    = 0;
    localparam logic [7:0] TMSC_CFG_WMASK     = 8'h7F;

    // field encodings
    localparam logic [1:0] TMSC_MODE_SCAN     = 2'h0;
    localparam logic [3:0] TMSC_EN_STOP       = 4'h0;
    localparam logic [3:0] TMSC_EN_ONE        = 4'h1;
    localparam logic [3:0] TMSC_EN_TWO        = 4'h2;

    // reset values
    localparam logic [7:0] TMSC_STATUS_RST    = 8'h00;
    localparam logic [7:0] TMSC_CONFIG_RST    = 8'h00;

    // serial slave address, value is arbitrary
    localparam logic [6:0] TMSC_I2C_ADDR      = 7'h2A;

    // run state of the sensing engine
    typedef enum logic [1:0] {
        TMSC_STOP,
        TMSC_SCAN,
        TMSC_AREA
    } tmsc_run_t;

    // serial slave states
    typedef enum logic [2:0] {
        TMSC_I_IDLE,
        TMSC_I_ADDR,
        TMSC_I_AACK,
        TMSC_I_WR,
        TMSC_I_WACK,
        TMSC_I_RD,
        TMSC_I_RACK
    } tmsc_i2c_t;

endpackage

/* File: tmsc_top.sv */
`timescale 1ns/1ps
module tmsc_top
    import tmsc_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    resetn,
    // serial bus pins
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output      logic                    sda_oe,
    output      logic                    sda_out,
    // shared interrupt / sense pin
    output      logic                    irq_oe,
    output      logic                    irq_out,
    output      logic                    shared_pin_is_sense,
    // overcurrent detector on the bias resistor pin
    input  wire logic                    bias_overcurrent,
    // measurement results from the front end
    input  wire logic                    meas_valid,
    input  wire logic [2:0][7:0]         meas_delta,
    input  wire logic [2:0][7:0]         touch_thr,
    input  wire logic [2:0][7:0]         release_thr,
    // front end control
    output      logic                    measure_enable,
    output      logic [2:0]              sense_enable,
    output      logic                    combine_inputs,
    output      logic                    baseline_cal_enable
);

    typedef struct packed {
        logic [1:0]  scl_s;
        logic [1:0]  sda_s;
        logic [1:0]  oc_s;
        logic        scl_p;
        logic        sda_p;
        tmsc_i2c_t   ist;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic        first;
        logic        rw;
        logic        nack;
        logic        sda_drv;
        logic [7:0]  status;
        logic [7:0]  cfg;
        logic        irq;
        logic        meas_en;
        logic [2:0]  sense_en;
        logic        comb;
        logic        cal_en;
        logic        pin_sense;
    } tmsc_state_t;

    tmsc_state_t s_q;
    tmsc_state_t s_d;

    // enable field to the set of active inputs
    function automatic logic [2:0] en_inputs(input logic [3:0] en);
        case (en)
            TMSC_EN_STOP: en_inputs = 3'h0;
            TMSC_EN_ONE:  en_inputs = 3'h1;
            TMSC_EN_TWO:  en_inputs = 3'h3;
            default:      en_inputs = 3'h7;
        endcase
    endfunction

    // hysteretic touch decision for one input
    function automatic logic touch_next(input logic cur, input logic [7:0] d,
                                        input logic [7:0] thr_t, input logic [7:0] thr_r);
        if (!cur) begin
            touch_next = (d >= thr_t);
        end else begin
            touch_next = !(d < thr_r);
        end
    endfunction

    // register read decode
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] st,
                                            input logic [7:0] cf);
        case (a)
            TMSC_ADDR_STATUS: reg_read = st;
            TMSC_ADDR_CONFIG: reg_read = cf & TMSC_CFG_WMASK;
            default:          reg_read = 8'h00;
        endcase
    endfunction

    logic       scl_rise;
    logic       scl_fall;
    logic       i2c_start;
    logic       i2c_stop;
    tmsc_run_t  run;
    logic [2:0] act;
    logic       irq_pin_mode;

    // edges and bus conditions from the synchronised pins
    assign scl_rise  = s_q.scl_s[1] && !s_q.scl_p;
    assign scl_fall  = !s_q.scl_s[1] && s_q.scl_p;
    assign i2c_start = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_s[1] && s_q.sda_p;
    assign i2c_stop  = s_q.scl_s[1] && s_q.scl_p && s_q.sda_s[1] && !s_q.sda_p;

    // current run state from the configuration and the overcurrent flag
    always_comb begin
        act = en_inputs(s_q.cfg[TMSC_CFG_EN_MSB:TMSC_CFG_EN_LSB]);
        if (act == 3'h0 || s_q.status[TMSC_ST_OCF_BIT]) begin
            run = TMSC_STOP;
        end else if (s_q.cfg[TMSC_CFG_MODE_MSB:TMSC_CFG_MODE_LSB] == TMSC_MODE_SCAN) begin
            run = TMSC_SCAN;
        end else begin
            run = TMSC_AREA;
        end
        irq_pin_mode = !act[2];
    end

    // next state of everything
    always_comb begin
        logic [7:0] wbyte;
        logic       do_wr;
        logic [7:0] st_new;
        logic       clr_irq;
        wbyte   = 8'h00;
        do_wr   = 1'b0;
        clr_irq = 1'b0;
        st_new  = s_q.status;
        s_d     = s_q;

        // two-stage synchronisers and edge history
        s_d.scl_s = {s_q.scl_s[0], scl_in};
        s_d.sda_s = {s_q.sda_s[0], sda_in};
        s_d.oc_s  = {s_q.oc_s[0], bias_overcurrent};
        s_d.scl_p = s_q.scl_s[1];
        s_d.sda_p = s_q.sda_s[1];

        // serial slave
        if (i2c_start) begin
            s_d.ist   = TMSC_I_ADDR;
            s_d.cnt   = 4'h0;
            s_d.first = 1'b1;
        end else if (i2c_stop) begin
            s_d.ist = TMSC_I_IDLE;
        end else begin
            case (s_q.ist)
                TMSC_I_ADDR, TMSC_I_WR: begin
                    if (scl_rise) begin
                        s_d.sh  = {s_q.sh[6:0], s_q.sda_s[1]};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall && s_q.cnt == 4'h8) begin
                        s_d.cnt = 4'h0;
                        if (s_q.ist == TMSC_I_ADDR) begin
                            if (s_q.sh[7:1] == TMSC_I2C_ADDR) begin
                                s_d.ist = TMSC_I_AACK;
                                s_d.rw  = s_q.sh[0];
                            end else begin
                                s_d.ist = TMSC_I_IDLE;
                            end
                        end else begin
                            s_d.ist = TMSC_I_WACK;
                            if (s_q.first) begin
                                s_d.ptr   = s_q.sh;
                                s_d.first = 1'b0;
                            end else begin
                                do_wr   = 1'b1;
                                wbyte   = s_q.sh;
                                s_d.ptr = s_q.ptr + 8'h01;
                            end
                        end
                    end
                end
                TMSC_I_AACK: begin
                    if (scl_fall) begin
                        if (s_q.rw) begin
                            s_d.ist = TMSC_I_RD;
                            s_d.sh  = reg_read(s_q.ptr, s_q.status, s_q.cfg);
                            s_d.ptr = s_q.ptr + 8'h01;
                            clr_irq = 1'b1;
                        end else begin
                            s_d.ist = TMSC_I_WR;
                        end
                    end
                end
                TMSC_I_WACK: begin
                    if (scl_fall) begin
                        s_d.ist = TMSC_I_WR;
                    end
                end
                TMSC_I_RD: begin
                    if (scl_rise) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_q.cnt == 4'h8) begin
                            s_d.ist = TMSC_I_RACK;
                            s_d.cnt = 4'h0;
                        end else begin
                            s_d.sh = {s_q.sh[6:0], 1'b0};
                        end
                    end
                end
                TMSC_I_RACK: begin
                    if (scl_rise) begin
                        s_d.nack = s_q.sda_s[1];
                    end else if (scl_fall) begin
                        if (s_q.nack) begin
                            s_d.ist = TMSC_I_IDLE;
                        end else begin
                            s_d.ist = TMSC_I_RD;
                            s_d.sh  = reg_read(s_q.ptr, s_q.status, s_q.cfg);
                            s_d.ptr = s_q.ptr + 8'h01;
                        end
                    end
                end
                default: begin
                    s_d.ist = TMSC_I_IDLE;
                end
            endcase
        end

        // register writes
        if (do_wr && s_q.ptr == TMSC_ADDR_CONFIG) begin
            if (run == TMSC_STOP) begin
                s_d.cfg = wbyte & TMSC_CFG_WMASK;
            end else if (wbyte[TMSC_CFG_EN_MSB:TMSC_CFG_EN_LSB] == TMSC_EN_STOP) begin
                s_d.cfg[TMSC_CFG_EN_MSB:TMSC_CFG_EN_LSB] = TMSC_EN_STOP;
            end
        end
        if (do_wr && s_q.ptr == TMSC_ADDR_STATUS && wbyte[TMSC_ST_OCF_BIT]) begin
            st_new[TMSC_ST_OCF_BIT] = 1'b0;
        end

        // touch status update, only while running
        if (meas_valid && run != TMSC_STOP) begin
            for (int i = 0; i < TMSC_NUM_INPUTS; i++) begin
                if (run == TMSC_AREA && i != 0) begin
                    st_new[TMSC_ST_TOUCH_LSB + i] = 1'b0;
                end else if (act[i]) begin
                    st_new[TMSC_ST_TOUCH_LSB + i] = touch_next(s_q.status[i],
                        meas_delta[i], touch_thr[i], release_thr[i]);
                end else begin
                    st_new[TMSC_ST_TOUCH_LSB + i] = 1'b0;
                end
            end
        end

        // overcurrent wins over every clear
        if (s_q.oc_s[1]) begin
            st_new     = TMSC_STATUS_RST;
            st_new[TMSC_ST_OCF_BIT] = 1'b1;
            s_d.cfg[TMSC_CFG_EN_MSB:TMSC_CFG_EN_LSB] = TMSC_EN_STOP;
        end
        s_d.status = st_new;

        // latching interrupt, a new change beats a read clear
        if (st_new != s_q.status) begin
            s_d.irq = 1'b1;
        end else if (clr_irq) begin
            s_d.irq = 1'b0;
        end

        // front end controls and pin role
        s_d.meas_en   = (run != TMSC_STOP);
        s_d.sense_en  = (run != TMSC_STOP) ? act : 3'h0;
        s_d.comb      = (run == TMSC_AREA);
        s_d.cal_en    = (run != TMSC_STOP) && !s_q.cfg[TMSC_CFG_CAL_BIT];
        s_d.pin_sense = !irq_pin_mode;

        // serial data drive: ack slots and zero bits of read data
        s_d.sda_drv = (s_d.ist == TMSC_I_AACK) || (s_d.ist == TMSC_I_WACK) ||
                      ((s_d.ist == TMSC_I_RD) && !s_d.sh[7]);
    end

    // state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_q        <= '0;
            s_q.scl_s  <= 2'h3;
            s_q.sda_s  <= 2'h3;
            s_q.scl_p  <= 1'b1;
            s_q.sda_p  <= 1'b1;
            s_q.ist    <= TMSC_I_IDLE;
            s_q.status <= TMSC_STATUS_RST;
            s_q.cfg    <= TMSC_CONFIG_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign sda_oe              = s_q.sda_drv;
    assign sda_out             = 1'b0;
    assign irq_oe              = s_q.irq && !s_q.pin_sense;
    assign irq_out             = 1'b0;
    assign shared_pin_is_sense = s_q.pin_sense;
    assign measure_enable      = s_q.meas_en;
    assign sense_enable        = s_q.sense_en;
    assign combine_inputs      = s_q.comb;
    assign baseline_cal_enable = s_q.cal_en;

endmodule // tmsc_top

/* File: tmsc_host.sv */
`timescale 1ns/1ps
module tmsc_host
    import tmsc_pkg::*;
(
    // clock
    input  wire logic clk_sys,
    // bus wires
    input  wire logic sda,
    output      logic scl,
    output      logic sda_low
);
    int nacks = 0;
    // bus idles released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // one bus phase of 12 clocks, above the 8 clock minimum
    task automatic ph();
        repeat (12) @(posedge clk_sys);
    endtask
    // start or repeated start: sda falls while scl high
    task automatic start();
        ph();
        sda_low <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b0;
    endtask
    // stop: sda rises while scl high
    task automatic stop();
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b0;
        ph();
    endtask
    // one bit, data moved well clear of the scl fall
    task automatic bitx(input logic b, output logic r);
        repeat (3) @(posedge clk_sys);
        sda_low <= !b;
        ph();
        scl <= 1'b1;
        ph();
        r = sda;
        scl <= 1'b0;
    endtask
    // byte msb first, ninth bit released
    task automatic xfer(input logic [7:0] d, input logic chk, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, a);
        if (chk && a !== 1'b0) nacks++;
    endtask
    // pointer then data
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] q;
        start();
        xfer({TMSC_I2C_ADDR, 1'b0}, 1'b1, q);
        xfer(p, 1'b1, q);
        xfer(v, 1'b1, q);
        stop();
    endtask
    // pointer, repeated start, one byte with nack; the read frees the interrupt
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic [7:0] q;
        start();
        xfer({TMSC_I2C_ADDR, 1'b0}, 1'b1, q);
        xfer(p, 1'b1, q);
        start();
        xfer({TMSC_I2C_ADDR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b0, v);
        stop();
    endtask
endmodule // tmsc_host

/* File: tmsc_top_asserts.sv */
`timescale 1ns/1ps
module tmsc_chk
    import tmsc_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       resetn,
    // watched pins
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       irq_oe,
    input wire logic       irq_out,
    input wire logic       shared_pin_is_sense,
    input wire logic       bias_overcurrent,
    input wire logic       measure_enable,
    input wire logic [2:0] sense_enable,
    input wire logic       combine_inputs,
    input wire logic       baseline_cal_enable
);
    logic [3:0] quiet_q;
    logic       scl_last_q;
    // cycles since scl last moved, saturating
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet_q    <= 4'h0;
            scl_last_q <= 1'b1;
        end else begin
            scl_last_q <= scl_in;
            if (scl_in != scl_last_q) quiet_q <= 4'h0;
            else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // settled run states
    sequence s_three;
        (measure_enable && sense_enable == 3'b111)[*3];
    endsequence
    sequence s_irq_pin;
        (measure_enable && sense_enable != 3'b111)[*3];
    endsequence
    AST_OPEN_DRAIN: assert property (sda_out == 1'b0 && irq_out == 1'b0)
        else $error("open drain data level not low");
    AST_IRQ_OFF_SENSE: assert property (irq_oe |-> !shared_pin_is_sense)
        else $error("interrupt driven on sense pin");
    AST_STOP_QUIET: assert property (!measure_enable |->
        sense_enable == 3'b000 && !combine_inputs && !baseline_cal_enable)
        else $error("front end active in stop");
    AST_EN_CODES: assert property (measure_enable |->
        sense_enable inside {3'b001, 3'b011, 3'b111})
        else $error("bad input enable set");
    AST_THREE_SENSE: assert property (s_three |-> shared_pin_is_sense)
        else $error("three inputs without sense pin");
    AST_TWO_IRQ: assert property (s_irq_pin |-> !shared_pin_is_sense)
        else $error("shared pin not interrupt");
    AST_OC_STOP: assert property ($rose(bias_overcurrent) |-> ##[1:8] !measure_enable)
        else $error("overcurrent did not stop");
    AST_OC_HOLD: assert property (bias_overcurrent[*8] |-> !measure_enable)
        else $error("run during overcurrent");
    // a pin turning into a sense input also drops the drive; only a read may free it
    AST_IRQ_LATCH: assert property ($fell(irq_oe) && !shared_pin_is_sense |-> quiet_q < 4'h8)
        else $error("interrupt dropped without bus activity");
endmodule // tmsc_chk

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import tmsc_pkg::*;
    // clock, reset, bus
    logic             clk_sys, resetn, scl, host_low;
    logic             sda_oe, sda_out, irq_oe, irq_out, shared_pin_is_sense;
    wire logic        sda_w = !(sda_oe | host_low);
    // front end
    logic             bias_overcurrent, meas_valid;
    logic [2:0][7:0]  meas_delta, touch_thr, release_thr;
    logic             measure_enable, combine_inputs, baseline_cal_enable;
    logic [2:0]       sense_enable;
    int               failures = 0, n_checks = 0, cycles = 0;
    tmsc_top DUT (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda_w),
        .sda_oe(sda_oe), .sda_out(sda_out), .irq_oe(irq_oe), .irq_out(irq_out),
        .shared_pin_is_sense(shared_pin_is_sense), .bias_overcurrent(bias_overcurrent),
        .meas_valid(meas_valid), .meas_delta(meas_delta), .touch_thr(touch_thr),
        .release_thr(release_thr), .measure_enable(measure_enable),
        .sense_enable(sense_enable), .combine_inputs(combine_inputs),
        .baseline_cal_enable(baseline_cal_enable));
    tmsc_host host (.clk_sys(clk_sys), .sda(sda_w), .scl(scl), .sda_low(host_low));
    // clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] v;
        host.rd(p, v);
        check("register", v, e);
    endtask
    function automatic logic [7:0] outs();
        return {1'b0, measure_enable, combine_inputs, baseline_cal_enable,
            shared_pin_is_sense, sense_enable};
    endfunction
    // front end outputs expected for a config value
    function automatic logic [7:0] exp_outs(input logic [7:0] v);
        logic       run;
        logic [2:0] se;
        run = v[3:0] != 4'h0;
        se = !run ? 3'h0 : v[3:0] == 4'h1 ? 3'h1 : v[3:0] == 4'h2 ? 3'h3 : 3'h7;
        return {1'b0, run, run && v[5:4] != 2'h0, run && !v[6], run && se == 3'h7, se};
    endfunction
    // one measurement pulse with deltas for inputs 0..2
    task automatic meas(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        @(posedge clk_sys);
        meas_delta <= {c, b, a};
        meas_valid <= 1'b1;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        check("outs", outs(), 8'h00);
        check("irq", {7'h00, irq_oe}, 8'h00);
        rc(TMSC_ADDR_STATUS, TMSC_STATUS_RST);
        rc(TMSC_ADDR_CONFIG, TMSC_CONFIG_RST);
    endtask
    task automatic t_modes();
        logic [7:0] tbl [9] = '{8'h01, 8'h02, 8'h03, 8'h0F, 8'h11, 8'h22, 8'h2F, 8'h30, 8'hC5};
        foreach (tbl[i]) begin
            host.wr(TMSC_ADDR_CONFIG, 8'h00);
            host.wr(TMSC_ADDR_CONFIG, tbl[i]);
            check("outs", outs(), exp_outs(tbl[i]));
            rc(TMSC_ADDR_CONFIG, tbl[i] & TMSC_CFG_WMASK);
        end
    endtask
    task automatic t_lock();
        host.wr(TMSC_ADDR_CONFIG, 8'h13);
        rc(TMSC_ADDR_CONFIG, 8'h45);
        host.wr(TMSC_ADDR_CONFIG, 8'h30);
        rc(TMSC_ADDR_CONFIG, 8'h40);
    endtask
    task automatic t_touch();
        host.wr(TMSC_ADDR_CONFIG, 8'h02);
        meas(8'h32, 8'h32, 8'h32);
        check("irq", {7'h00, irq_oe}, 8'h01);
        rc(TMSC_ADDR_STATUS, 8'h03);
        check("irq", {7'h00, irq_oe}, 8'h00);
        meas(8'h1E, 8'h1E, 8'h1E);
        check("irq", {7'h00, irq_oe}, 8'h00);
        meas(8'h0A, 8'h1E, 8'h00);
        check("irq", {7'h00, irq_oe}, 8'h01);
        rc(TMSC_ADDR_STATUS, 8'h02);
        host.wr(TMSC_ADDR_STATUS, 8'h7F);
        rc(TMSC_ADDR_STATUS, 8'h02);
        host.wr(TMSC_ADDR_CONFIG, 8'h00);
        meas(8'h32, 8'h0A, 8'h32);
        rc(TMSC_ADDR_STATUS, 8'h02);
        host.wr(TMSC_ADDR_CONFIG, 8'h13);
        meas(8'h32, 8'h32, 8'h32);
        check("irq", {7'h00, irq_oe}, 8'h00);
        rc(TMSC_ADDR_STATUS, 8'h01);
    endtask
    task automatic t_oc();
        bias_overcurrent <= 1'b1;
        repeat (10) @(posedge clk_sys);
        check("run", {7'h00, measure_enable}, 8'h00);
        rc(TMSC_ADDR_STATUS, 8'h80);
        rc(TMSC_ADDR_CONFIG, 8'h10);
        bias_overcurrent <= 1'b0;
        host.wr(TMSC_ADDR_CONFIG, 8'h01);
        check("run", {7'h00, measure_enable}, 8'h00);
        host.wr(TMSC_ADDR_STATUS, 8'h80);
        rc(TMSC_ADDR_STATUS, 8'h00);
        host.wr(TMSC_ADDR_CONFIG, 8'h00);
        host.wr(TMSC_ADDR_CONFIG, 8'h01);
        check("outs", outs(), exp_outs(8'h01));
    endtask
    // main sequence
    initial begin
        resetn           = 1'b0;
        bias_overcurrent = 1'b0;
        meas_valid       = 1'b0;
        meas_delta       = '0;
        touch_thr        = {3{8'h28}};
        release_thr      = {3{8'h14}};
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_modes();
        t_lock();
        t_touch();
        t_oc();
        check("acks", host.nacks[7:0], 8'h00);
        final_report();
    end
endmodule // tb
bind tmsc_top tmsc_chk CHK (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in),
    .sda_out(sda_out), .irq_oe(irq_oe), .irq_out(irq_out),
    .shared_pin_is_sense(shared_pin_is_sense), .bias_overcurrent(bias_overcurrent),
    .measure_enable(measure_enable), .sense_enable(sense_enable),
    .combine_inputs(combine_inputs), .baseline_cal_enable(baseline_cal_enable));
